/* logic/tws_map.svh */
// Offsets, field positions, reset values and timing counts of the port
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define TWS_CLK_PERIOD_NS 40
`define TWS_PARK_NS 100000
`define TWS_PARK_CYC ((`TWS_PARK_NS + `TWS_CLK_PERIOD_NS - 1) / `TWS_CLK_PERIOD_NS)
// ------------------------------------------------------------
// Instruction fields
// ------------------------------------------------------------
`define TWS_INS_RW 15
`define TWS_INS_LEN_HI 14
`define TWS_INS_LEN_LO 13
`define TWS_INS_BITS 16
`define TWS_LEN_STREAM 2'b11
// ------------------------------------------------------------
// Serial register space
// ------------------------------------------------------------
`define TWS_SA_CFG 13'h0000
`define TWS_SA_SHD_BASE 10'h001
`define TWS_SA_UPDATE 13'h00FF
`define TWS_CFG_RESET 8'h18
`define TWS_CFG_LSB_A 6
`define TWS_CFG_LSB_B 1
`define TWS_UPD_BIT 0
`define TWS_SHD_RESET 8'h00
// ------------------------------------------------------------
// APB register offsets
// ------------------------------------------------------------
`define TWS_APB_CTRL 8'h00
`define TWS_APB_STATUS 8'h04
`define TWS_APB_CFG 8'h08
`define TWS_APB_ACT_BASE 3'b001
`define TWS_CTRL_RESET 32'h0000_0001
`define TWS_CTRL_EN 0
`endif

/* logic/tws_pkg.sv */
// Types shared by the three-wire serial port
package tws_pkg;
  typedef enum logic [1:0] {
    TWS_IDLE = 2'b00,
    TWS_INSTR = 2'b01,
    TWS_DATA = 2'b10,
    TWS_DONE = 2'b11
  } tws_phase_t;
endpackage

/* logic/tws_port.sv */
// Three-wire configuration serial port with APB status and control
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"

module tws_port
  import tws_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE,
  output logic SEC_FN_EN,
  output logic [63:0] ACTIVE_REGS
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sdi_s1_q, sdi_s2_q;

  // Two flops per pin; the third sclk/cs flop feeds edge detection only
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= SCLK;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= CS_N;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sdi_s1_q <= SDIO_I;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // ------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------
  tws_phase_t phase_q;
  logic [31:0] ctrl_q;
  logic [3:0] bit_cnt_q;
  logic [14:0] instr_q;
  logic rd_q, stream_q;
  logic [1:0] left_q;
  logic [12:0] addr_q;
  logic [7:0] rx_q, tx_q;
  logic [7:0] cfg_q;
  logic [7:0] shadow_q [8];
  logic [7:0] active_q [8];
  logic [7:0] frames_q;
  logic [11:0] park_q;
  logic oe_q, sdo_q;
  logic [31:0] prdata_q;

  wire port_en = ctrl_q[`TWS_CTRL_EN];
  wire cs_low = ~cs_s2_q & port_en;
  wire cs_rise = cs_s2_q & ~cs_s3_q;
  // Clock edges only count while selected, so bus noise is harmless
  wire rise = sclk_s2_q & ~sclk_s3_q & cs_low;
  wire fall = ~sclk_s2_q & sclk_s3_q & cs_low;
  wire sdi = sdi_s2_q;
  wire lsb_first = cfg_q[`TWS_CFG_LSB_A] | cfg_q[`TWS_CFG_LSB_B];
  wire [15:0] instr_full = {instr_q, sdi};
  wire instr_last = (phase_q == TWS_INSTR) && (bit_cnt_q == 4'hF);
  wire byte_last = (phase_q == TWS_DATA) && (bit_cnt_q == 4'h7);
  wire [12:0] addr_step = lsb_first ? (addr_q + 13'h0001)
                                    : (addr_q - 13'h0001);
  // Address of the byte to be fetched for the next read word
  wire [12:0] rd_addr = (phase_q == TWS_INSTR) ? instr_full[12:0] : addr_step;
  wire rd_cfg = (rd_addr == `TWS_SA_CFG);
  wire rd_shd = (rd_addr[12:3] == `TWS_SA_SHD_BASE);
  wire [7:0] rd_byte = rd_cfg ? cfg_q
                     : rd_shd ? shadow_q[rd_addr[2:0]] : 8'h00;
  // Assembled write byte in either bit order
  wire [7:0] wr_byte = lsb_first ? {sdi, rx_q[7:1]} : {rx_q[6:0], sdi};
  wire wr_stb = rise & byte_last & ~rd_q;
  wire wr_cfg = wr_stb & (addr_q == `TWS_SA_CFG);
  wire wr_shd = wr_stb & (addr_q[12:3] == `TWS_SA_SHD_BASE);
  // Transfer bit reads back as zero, so it clears by itself
  wire upd_stb = wr_stb & (addr_q == `TWS_SA_UPDATE)
               & wr_byte[`TWS_UPD_BIT];
  wire data_rd = (phase_q == TWS_DATA) & rd_q;
  wire frame_end = rise & byte_last & ~stream_q & (left_q == 2'b00);
  // A stall is only legal on a byte boundary of a counted frame
  wire stall_ok = (phase_q == TWS_DATA) && (bit_cnt_q == 4'h0)
                && !stream_q;

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  // Bit position survives select going high between bytes of a counted frame
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_q <= TWS_IDLE;
      bit_cnt_q <= 4'h0;
      instr_q <= 15'h0000;
      rd_q <= 1'b0;
      stream_q <= 1'b0;
      left_q <= 2'b00;
      addr_q <= 13'h0000;
      rx_q <= 8'h00;
    end else if (cs_rise && !stall_ok) begin
      phase_q <= TWS_IDLE;
    end else if (rise) begin
      case (phase_q)
        TWS_IDLE: begin
          phase_q <= TWS_INSTR;
          instr_q <= {14'h0000, sdi};
          bit_cnt_q <= 4'h1;
        end
        TWS_INSTR: begin
          instr_q <= instr_full[14:0];
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (instr_last) begin
            phase_q <= TWS_DATA;
            bit_cnt_q <= 4'h0;
            rd_q <= instr_full[`TWS_INS_RW];
            left_q <= instr_full[`TWS_INS_LEN_HI:`TWS_INS_LEN_LO];
            stream_q <= (instr_full[`TWS_INS_LEN_HI:`TWS_INS_LEN_LO]
                         == `TWS_LEN_STREAM);
            addr_q <= instr_full[12:0];
          end
        end
        TWS_DATA: begin
          rx_q <= lsb_first ? {sdi, rx_q[7:1]} : {rx_q[6:0], sdi};
          bit_cnt_q <= byte_last ? 4'h0 : bit_cnt_q + 4'h1;
          if (byte_last) begin
            addr_q <= addr_step;
            left_q <= left_q - 2'b01;
            if (frame_end) begin
              phase_q <= TWS_DONE;
            end
          end
        end
        default: begin
          phase_q <= TWS_DONE; // Extra clocks wait for select high
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read data shifter and pin turnaround
  // ------------------------------------------------------------
  // Output changes on falling shift edges so the master samples on rising
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (rise && (instr_last || byte_last)) begin
        tx_q <= rd_byte;
      end else if (fall && data_rd) begin
        tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
      end
      if (fall && data_rd) begin
        sdo_q <= lsb_first ? tx_q[0] : tx_q[7];
      end
      if (!cs_low || !data_rd) begin
        oe_q <= 1'b0;
      end else if (fall) begin
        oe_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial register space
  // ------------------------------------------------------------
  // Port configuration acts at once; it is not shadowed
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= `TWS_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= wr_byte;
    end
  end

  // Shadow and active copy of each configuration byte
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_reg
      always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          shadow_q[gi] <= `TWS_SHD_RESET;
          active_q[gi] <= `TWS_SHD_RESET;
        end else begin
          if (wr_shd && (addr_q[2:0] == 3'(gi))) begin
            shadow_q[gi] <= wr_byte;
          end
          if (upd_stb) begin
            active_q[gi] <= shadow_q[gi];
          end
        end
      end
      assign ACTIVE_REGS[gi*8 +: 8] = active_q[gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // Park detection and frame counter
  // ------------------------------------------------------------
  // Long idle select means the pins serve their other purpose
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      park_q <= 12'h000;
    end else if (!cs_s2_q) begin
      park_q <= 12'h000;
    end else if (park_q != 12'(`TWS_PARK_CYC)) begin
      park_q <= park_q + 12'h001;
    end
  end

  // Counts counted-length frames that ran to their final byte; stream frames are never counted
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      frames_q <= 8'h00;
    end else if (frame_end) begin
      frames_q <= frames_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire hit_ctrl = (PADDR == `TWS_APB_CTRL);
  wire hit_stat = (PADDR == `TWS_APB_STATUS);
  wire hit_cfg = (PADDR == `TWS_APB_CFG);
  wire hit_act = (PADDR[7:5] == `TWS_APB_ACT_BASE) && (PADDR[1:0] == 2'b00);
  wire hit_any = hit_ctrl | hit_stat | hit_cfg | hit_act;
  wire parked = (park_q == 12'(`TWS_PARK_CYC));
  wire [31:0] status = {16'h0000, frames_q, 4'h0, parked, lsb_first,
                        stream_q, (phase_q != TWS_IDLE)};
  wire [31:0] rd_mux;

  // Address decode for reads; unmapped offsets read zero
  assign rd_mux = hit_ctrl ? ctrl_q
                : hit_stat ? status
                : hit_cfg ? {24'h000000, cfg_q}
                : hit_act ? {24'h000000, active_q[PADDR[4:2]]}
                : 32'h0000_0000;

  // Read data is caught in the setup cycle so the access needs no wait
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q <= 32'h0000_0000;
      ctrl_q <= `TWS_CTRL_RESET;
    end else begin
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_q <= {31'h0000_0000, PWDATA[`TWS_CTRL_EN]};
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  // Data pin only driven while a read word is under way
  assign SDIO_O = sdo_q;
  assign SDIO_OE = oe_q;
  assign SEC_FN_EN = parked;

endmodule
`default_nettype wire

/* bench/tws_port_properties.sv */
// Concurrent checks on the serial port pins and the APB side
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
module tws_chk (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_O,
  input wire logic SDIO_OE,
  input wire logic SEC_FN_EN,
  input wire logic [63:0] ACTIVE_REGS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  localparam int PARK = `TWS_PARK_CYC;
  logic [12:0] hi_q;
  // Raw select-high time; the design sees it two flops later
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) hi_q <= 13'h0000;
    else if (!CS_N) hi_q <= 13'h0000;
    else if (hi_q != 13'h1FFF) hi_q <= hi_q + 13'h0001;
  end
  // A finished transfer followed by an idle bus cycle
  sequence apb_done;
    PSEL && !PENABLE ##1 PSEL && PENABLE ##1 !PSEL;
  endsequence
  ready_in_access_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase without ready");
  hole_flagged_a: assert property (PSEL && PENABLE && PADDR == 8'h0C
    |-> PSLVERR) else $error("unmapped access not flagged");
  rdata_holds_a: assert property (apb_done |-> $stable(PRDATA))
    else $error("read data moved after transfer");
  oe_idle_a: assert property (CS_N [*5] |-> !SDIO_OE)
    else $error("data pin driven while deselected");
  oe_turn_a: assert property ($rose(SDIO_OE) |->
    !$past(CS_N, 3) && !$past(SCLK, 2)) else $error("bad turnaround");
  bit_step_a: assert property (SDIO_OE && $past(SDIO_OE) &&
    $changed(SDIO_O) |-> !$past(SCLK, 2)) else $error("bit moved early");
  apply_in_frame_a: assert property ($changed(ACTIVE_REGS) |->
    !$past(CS_N, 3)) else $error("active bytes moved outside a frame");
  park_late_a: assert property (hi_q >= PARK + 8 |-> SEC_FN_EN)
    else $error("park not entered");
  park_early_a: assert property ($rose(SEC_FN_EN) |-> hi_q >= PARK)
    else $error("park entered too soon");
  park_exit_a: assert property (!CS_N [*4] |-> !SEC_FN_EN)
    else $error("park held while selected");
endmodule
bind tws_port tws_chk chk (.CLOCK, .ARST_N, .PSEL, .PENABLE, .PADDR,
  .PRDATA, .PREADY, .PSLVERR, .SCLK, .CS_N, .SDIO_O, .SDIO_OE,
  .SEC_FN_EN, .ACTIVE_REGS);
`default_nettype wire

/* bench/tws_master.sv */
// Serial programming master on the far side of the three-wire port
`timescale 1ns/1ps
`default_nettype none
module tws_master (
  output logic SCLK,
  output logic CS_N,
  output logic SD_O,
  output logic SD_OE,
  input wire logic SD_I
);
  localparam int HALF = 160;
  // Clock idles low and select starts high
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SD_O = 1'b0;
    SD_OE = 1'b0;
  end
  // Data moves at the fall; read bits are taken midway through the high half
  task automatic bitx(input logic d, input logic drv, output logic q);
    SD_O <= d;
    SD_OE <= drv;
    #HALF SCLK <= 1'b1;
    #(HALF / 2) q = SD_I;
    #(HALF / 2) SCLK <= 1'b0;
  endtask
  // Clock pulses with select high must be ignored
  task automatic noise();
    logic q;
    repeat (3) bitx(1'b1, 1'b1, q);
  endtask
  // Whole frame: instruction MSB first, then n bytes
  task automatic frame(input logic rd, input logic [1:0] len,
    input logic [12:0] a, input int n, input logic [31:0] wd,
    input bit lsb, input bit stall, output logic [31:0] rv);
    logic [15:0] ins;
    logic q;
    int b;
    ins = {rd, len, a};
    rv = 32'h0000_0000;
    CS_N <= 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--) bitx(ins[i], 1'b1, q);
    for (int k = 0; k < n; k++) begin
      if (stall && k > 0) begin
        CS_N <= 1'b1;
        #(4 * HALF) CS_N <= 1'b0;
        #HALF;
      end
      for (int j = 0; j < 8; j++) begin
        b = 8 * k + (lsb ? j : 7 - j);
        bitx(wd[b], !rd, q);
        rv[b] = q;
      end
    end
    SD_OE <= 1'b0;
    #HALF CS_N <= 1'b1;
    #(4 * HALF);
  endtask
endmodule
`default_nettype wire

/* bench/test_tws_port.sv */
// Self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.svh"
`define CHK(a, b) check_val(64'(a), 64'(b))
module test_tws_port;
  logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, sclk, cs_n, sdo, soe, m_d, m_oe;
  logic sec_fn, e, junk_q = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv, rd, d;
  logic [63:0] act;
  logic [7:0] shd [8];
  int bad_count = 0, check_count = 0;
  wire logic sdio;
  // Released line toggles so a stale level never passes as data
  assign sdio = (soe && m_oe) ? 1'bx : soe ? sdo : m_oe ? m_d : junk_q;
  tws_port dut (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCLK(sclk),
    .CS_N(cs_n), .SDIO_I(sdio), .SDIO_O(sdo), .SDIO_OE(soe),
    .SEC_FN_EN(sec_fn), .ACTIVE_REGS(act));
  tws_master m (.SCLK(sclk), .CS_N(cs_n), .SD_O(m_d), .SD_OE(m_oe),
    .SD_I(sdio));
  // Clock and released-line pattern
  always #20 clock = ~clock;
  always @(posedge clock) junk_q <= ~junk_q;
  task automatic check_val(input logic [63:0] got, input logic [63:0] x);
    check_count++;
    if (got !== x) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // APB transfer; waits for ready, only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q, output logic er);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [12:0] at(logic [12:0] a, int k, bit lsb);
    return lsb ? a + 13'(k) : a - 13'(k);
  endfunction
  function automatic logic [63:0] shd_all();
    logic [63:0] v;
    for (int i = 0; i < 8; i++) v[8 * i +: 8] = shd[i];
    return v;
  endfunction
  // Serial write that also updates the expected shadow bytes
  task automatic sw(logic [1:0] len, logic [12:0] a, int n,
    logic [31:0] wd, bit lsb, bit st);
    m.frame(1'b0, len, a, n, wd, lsb, st, rd);
    for (int k = 0; k < n; k++) begin
      if (at(a, k, lsb) >> 3 == 13'(`TWS_SA_SHD_BASE))
        shd[3'(at(a, k, lsb))] = wd[8 * k +: 8];
    end
  endtask
  // Watchdog well beyond the expected run of about 0.24 ms
  initial begin
    #2_000_000;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h9d7f));
    for (int i = 0; i < 8; i++) shd[i] = 8'h00;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    apb(1'b0, `TWS_APB_CFG, 32'h0000_0000, rv, e);
    `CHK(rv, 32'h0000_0018);
    apb(1'b0, 8'h0C, 32'h0000_0000, rv, e);
    `CHK({e, rv}, 33'h1_0000_0000);
    $display("test defaults done");
    repeat (2600) @(posedge clock);
    `CHK({sec_fn, soe}, 2'b10);
    $display("test park done");
    m.noise();
    d = $urandom();
    sw(2'b10, 13'h000A, 3, d, 1'b0, 1'b0);
    `CHK(act, 64'h0000_0000_0000_0000);
    m.frame(1'b1, 2'b00, 13'h0009, 1, 32'h0000_0000, 1'b0, 1'b0, rd);
    `CHK(rd[7:0], shd[1]);
    sw(2'b00, `TWS_SA_UPDATE, 1, 32'h0000_0001, 1'b0, 1'b0);
    `CHK(act, shd_all());
    m.frame(1'b1, 2'b00, `TWS_SA_UPDATE, 1, 32'h0000_0000, 1'b0, 1'b0, rd);
    `CHK(rd[7:0], 8'h00);
    $display("test shadow done");
    sw(2'b01, 13'h000D, 2, $urandom(), 1'b0, 1'b1);
    sw(2'b11, 13'h000F, 4, $urandom(), 1'b0, 1'b0);
    m.frame(1'b1, 2'b11, 13'h000F, 4, 32'h0000_0000, 1'b0, 1'b0, rd);
    `CHK(rd, {shd[4], shd[5], shd[6], shd[7]});
    sw(2'b00, `TWS_SA_UPDATE, 1, 32'h0000_0001, 1'b0, 1'b0);
    `CHK(act, shd_all());
    $display("test stall and stream done");
    sw(2'b00, `TWS_SA_CFG, 1, 32'h0000_0042, 1'b0, 1'b0);
    apb(1'b0, `TWS_APB_STATUS, 32'h0000_0000, rv, e);
    `CHK(rv[2], 1'b1);
    sw(2'b01, 13'h0008, 2, $urandom(), 1'b1, 1'b0);
    m.frame(1'b1, 2'b01, 13'h0008, 2, 32'h0000_0000, 1'b1, 1'b0, rd);
    `CHK(rd[15:0], {shd[1], shd[0]});
    sw(2'b00, `TWS_SA_UPDATE, 1, 32'h0000_0001, 1'b1, 1'b0);
    `CHK(act, shd_all());
    $display("test lsb order done");
    end_sim();
  end
endmodule
`default_nettype wire
